// >>> hw/uart_ctl_defines.svh
// Offsets, field positions, reset values and timing counts of the serial port control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef UART_CTL_DEFINES_SVH
`define UART_CTL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------
`define OFS_INT_STATUS 8'h00
`define OFS_INT_MASK 8'h04
`define OFS_DIV_UPPER 8'h08
`define OFS_DIV_LOWER 8'h0C
`define OFS_INT_VECTOR 8'h10
`define OFS_INPUT_PORT 8'h14
`define OFS_OUT_ASSERT 8'h18
`define OFS_OUT_NEGATE 8'h1C
`define OFS_AUX_CTRL 8'h20
`define OFS_INPUT_CHANGE 8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_TX_READY 0
`define BIT_RX_OR_FULL 1
`define BIT_BREAK_CHANGE 2
`define BIT_CTS_CHANGE 7
`define BIT_CTS_LEVEL 0
`define BIT_CHANGE_FLAG 4
`define BIT_RTS_CMD 0
`define BIT_AUX_CHANGE_IRQ 0
`define BIT_AUX_AUTOVEC 1
`define STATUS_USED_MASK 8'h87

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RST_INT_VECTOR 8'h0F
`define RST_INT_MASK 8'h00
`define RST_DIVIDER 8'h00
`define RST_AUX_CTRL 8'h00
`define PRESCALE_DIV 6'h20
`define DIVIDER_MIN 16'h0002

`endif

// >>> hw/uart_ctl_pkg.sv
// Types shared by the serial port control block.
// Assumes the defines header is on the include path.
package uart_ctl_pkg;
	`include "uart_ctl_defines.svh"

	typedef logic [7:0] reg8_t;
	typedef logic [15:0] divider_t;

	// Register selected by a bus access
	typedef enum logic [10:0] {
		SEL_NONE = 11'h001,
		SEL_STATUS = 11'h002,
		SEL_MASK = 11'h004,
		SEL_DIV_UP = 11'h008,
		SEL_DIV_LO = 11'h010,
		SEL_VECTOR = 11'h020,
		SEL_INPORT = 11'h040,
		SEL_OUT_SET = 11'h080,
		SEL_OUT_CLR = 11'h100,
		SEL_AUX = 11'h200,
		SEL_CHANGE = 11'h400
	} reg_sel_t;
endpackage

// >>> hw/uart_ctl.sv
// Serial port channel control: interrupt status and mask, baud divider,
// interrupt vector, clear-to-send input port and request-to-send commands.
// Assumes an AHB-Lite master on clk, and shifters and receive FIFO outside
// that supply the ready, full and break-edge flags.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`include "uart_ctl_defines.svh"

module uart_ctl #(
	parameter int CHANNEL = 0
) (
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Flags from the channel's shifters and FIFO
	input wire logic transmit_ready_flag,
	input wire logic receive_ready_flag,
	input wire logic fifo_full_flag,
	input wire logic fifo_full_select,
	input wire logic break_edge,
	input wire logic reset_break_change,
	input wire logic tx_holding_write,
	output logic tx_holding_accept,
	// Clock source
	input wire logic bus_clock_select,
	output logic [15:0] baud_divider,
	output logic serial_clk_en,
	// Interrupt and DMA
	output logic irq_n,
	output logic dma_req_ch2,
	output logic dma_req_ch3,
	input wire logic int_ack,
	output logic [7:0] ack_vector,
	output logic ack_autovector,
	output logic ack_valid,
	// Modem pins
	input wire logic cts_n,
	output logic rts_n
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	uart_ctl_pkg::reg8_t interrupt_mask_reg;
	uart_ctl_pkg::reg8_t baud_divider_upper_reg;
	uart_ctl_pkg::reg8_t baud_divider_lower_reg;
	uart_ctl_pkg::reg8_t interrupt_vector_reg;
	uart_ctl_pkg::reg8_t auxiliary_control_reg;
	logic break_change_flag_reg;
	logic cts_change_flag_reg;
	logic rts_active_reg;
	logic cts_sync1_reg;
	logic cts_sync2_reg;
	logic cts_sync3_reg;
	logic cts_level_reg;
	logic cts_level_next;
	logic cts_edge;
	logic wr_pending_reg;
	uart_ctl_pkg::reg_sel_t wr_sel_reg;
	uart_ctl_pkg::reg_sel_t addr_sel;
	logic access;
	logic rd_access;
	uart_ctl_pkg::reg8_t interrupt_status;
	uart_ctl_pkg::reg8_t rd_byte;
	logic [5:0] prescale_reg;
	logic [15:0] divcount_reg;
	logic prescale_tick;
	logic change_read;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Used for both the read mux and the write capture
	function automatic uart_ctl_pkg::reg_sel_t decode(input logic [7:0] a);
		case (a)
			`OFS_INT_STATUS: decode = uart_ctl_pkg::SEL_STATUS;
			`OFS_INT_MASK: decode = uart_ctl_pkg::SEL_MASK;
			`OFS_DIV_UPPER: decode = uart_ctl_pkg::SEL_DIV_UP;
			`OFS_DIV_LOWER: decode = uart_ctl_pkg::SEL_DIV_LO;
			`OFS_INT_VECTOR: decode = uart_ctl_pkg::SEL_VECTOR;
			`OFS_INPUT_PORT: decode = uart_ctl_pkg::SEL_INPORT;
			`OFS_OUT_ASSERT: decode = uart_ctl_pkg::SEL_OUT_SET;
			`OFS_OUT_NEGATE: decode = uart_ctl_pkg::SEL_OUT_CLR;
			`OFS_AUX_CTRL: decode = uart_ctl_pkg::SEL_AUX;
			`OFS_INPUT_CHANGE: decode = uart_ctl_pkg::SEL_CHANGE;
			default: decode = uart_ctl_pkg::SEL_NONE;
		endcase
	endfunction

	// Zero wait states: every transfer finishes in one data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign access = hsel & htrans[1] & hready;
	assign rd_access = access & ~hwrite;
	assign addr_sel = decode(haddr);
	assign change_read = rd_access && (addr_sel == uart_ctl_pkg::SEL_CHANGE);

	// Capture write address phase; data arrives one cycle later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pending_reg <= 1'b0;
			wr_sel_reg <= uart_ctl_pkg::SEL_NONE;
		end else if (hready) begin
			wr_pending_reg <= access & hwrite;
			wr_sel_reg <= addr_sel;
		end
	end

	// ----------------------------------------------------------------
	// Clear-to-send synchroniser
	// ----------------------------------------------------------------
	// Three flops; a change counts once the second and third agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cts_sync1_reg <= 1'b1;
			cts_sync2_reg <= 1'b1;
			cts_sync3_reg <= 1'b1;
			cts_level_reg <= 1'b1;
		end else begin
			cts_sync1_reg <= cts_n;
			cts_sync2_reg <= cts_sync1_reg;
			cts_sync3_reg <= cts_sync2_reg;
			cts_level_reg <= cts_level_next;
		end
	end

	assign cts_level_next = (cts_sync2_reg == cts_sync3_reg) ? cts_sync3_reg : cts_level_reg;
	assign cts_edge = cts_level_next != cts_level_reg;

	// Change flag: an edge in the clearing read's cycle still sets it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cts_change_flag_reg <= 1'b0;
		end else if (cts_edge) begin
			cts_change_flag_reg <= 1'b1;
		end else if (change_read) begin
			cts_change_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and request
	// ----------------------------------------------------------------
	// Break-change is sticky; set beats the reset command
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			break_change_flag_reg <= 1'b0;
		end else if (break_edge) begin
			break_change_flag_reg <= 1'b1;
		end else if (reset_break_change) begin
			break_change_flag_reg <= 1'b0;
		end
	end

	// Status built from live sources, never from the mask
	always_comb begin
		interrupt_status = 8'h00;
		interrupt_status[`BIT_CTS_CHANGE] = cts_change_flag_reg
			& auxiliary_control_reg[`BIT_AUX_CHANGE_IRQ];
		interrupt_status[`BIT_BREAK_CHANGE] = break_change_flag_reg;
		interrupt_status[`BIT_RX_OR_FULL] = fifo_full_select ? fifo_full_flag
			: receive_ready_flag;
		interrupt_status[`BIT_TX_READY] = transmit_ready_flag;
	end

	// Request is low whenever any unmasked status bit is set
	assign irq_n = ~|(interrupt_status & interrupt_mask_reg);

	// DMA request follows the masked FIFO-full source of this channel
	generate
		if (CHANNEL == 0) begin : g_ch0
			assign dma_req_ch2 = fifo_full_select & fifo_full_flag
				& interrupt_mask_reg[`BIT_RX_OR_FULL];
			assign dma_req_ch3 = 1'b0;
		end else begin : g_ch1
			assign dma_req_ch2 = 1'b0;
			assign dma_req_ch3 = fifo_full_select & fifo_full_flag
				& interrupt_mask_reg[`BIT_RX_OR_FULL];
		end
	endgenerate

	// Holding-register writes pass only while transmit-ready is set
	assign tx_holding_accept = tx_holding_write & transmit_ready_flag;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Mask, divider, vector and control bytes take the low data lane
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			interrupt_mask_reg <= `RST_INT_MASK;
			baud_divider_upper_reg <= `RST_DIVIDER;
			baud_divider_lower_reg <= `RST_DIVIDER;
			interrupt_vector_reg <= `RST_INT_VECTOR;
			auxiliary_control_reg <= `RST_AUX_CTRL;
		end else if (wr_pending_reg) begin
			case (wr_sel_reg)
				uart_ctl_pkg::SEL_MASK: begin
					interrupt_mask_reg <= hwdata[7:0] & `STATUS_USED_MASK;
				end
				uart_ctl_pkg::SEL_DIV_UP: begin
					baud_divider_upper_reg <= hwdata[7:0];
				end
				uart_ctl_pkg::SEL_DIV_LO: begin
					baud_divider_lower_reg <= hwdata[7:0];
				end
				uart_ctl_pkg::SEL_VECTOR: begin
					interrupt_vector_reg <= hwdata[7:0];
				end
				uart_ctl_pkg::SEL_AUX: begin
					auxiliary_control_reg <= {6'h00, hwdata[1:0]};
				end
				default: begin
				end
			endcase
		end
	end

	// Request-to-send: set and clear commands; a zero bit changes nothing
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rts_active_reg <= 1'b0;
		end else if (wr_pending_reg && hwdata[`BIT_RTS_CMD]) begin
			if (wr_sel_reg == uart_ctl_pkg::SEL_OUT_SET) begin
				rts_active_reg <= 1'b1;
			end else if (wr_sel_reg == uart_ctl_pkg::SEL_OUT_CLR) begin
				rts_active_reg <= 1'b0;
			end
		end
	end

	assign rts_n = ~rts_active_reg;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Divider and command registers read as zero; unmapped reads zero too
	always_comb begin
		rd_byte = 8'h00;
		case (addr_sel)
			uart_ctl_pkg::SEL_STATUS: rd_byte = interrupt_status;
			uart_ctl_pkg::SEL_MASK: rd_byte = interrupt_mask_reg;
			uart_ctl_pkg::SEL_VECTOR: rd_byte = interrupt_vector_reg;
			uart_ctl_pkg::SEL_INPORT: rd_byte[`BIT_CTS_LEVEL] = cts_level_reg;
			uart_ctl_pkg::SEL_AUX: rd_byte = auxiliary_control_reg;
			uart_ctl_pkg::SEL_CHANGE: begin
				rd_byte[`BIT_CHANGE_FLAG] = cts_change_flag_reg;
				rd_byte[`BIT_CTS_LEVEL] = cts_level_reg;
			end
			default: rd_byte = 8'h00;
		endcase
	end

	// Latched at the address phase so the pin level is frozen for the read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (rd_access) begin
			hrdata <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Baud rate generation
	// ----------------------------------------------------------------
	assign baud_divider = {baud_divider_upper_reg, baud_divider_lower_reg};

	// Fixed divide-by-32 prescaler on the bus clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale_reg <= 6'h00;
		end else if (!bus_clock_select || prescale_tick) begin
			prescale_reg <= 6'h00;
		end else begin
			prescale_reg <= prescale_reg + 6'h01;
		end
	end

	assign prescale_tick = bus_clock_select && (prescale_reg == `PRESCALE_DIV - 6'h01);

	// Divider counter; values below the minimum give a tick every prescale
	// period, which is why software must keep to the floor
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divcount_reg <= 16'h0000;
			serial_clk_en <= 1'b0;
		end else if (!bus_clock_select) begin
			divcount_reg <= 16'h0000;
			serial_clk_en <= 1'b0;
		end else if (prescale_tick) begin
			if (divcount_reg + 16'h0001 >= baud_divider) begin
				divcount_reg <= 16'h0000;
				serial_clk_en <= 1'b1;
			end else begin
				divcount_reg <= divcount_reg + 16'h0001;
				serial_clk_en <= 1'b0;
			end
		end else begin
			serial_clk_en <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt acknowledge
	// ----------------------------------------------------------------
	// One-cycle answer one edge after the acknowledge strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_valid <= 1'b0;
			ack_vector <= `RST_INT_VECTOR;
			ack_autovector <= 1'b0;
		end else begin
			ack_valid <= int_ack;
			if (int_ack) begin
				ack_vector <= interrupt_vector_reg;
				ack_autovector <= auxiliary_control_reg[`BIT_AUX_AUTOVEC];
			end
		end
	end

endmodule

// >>> sim/uart_ctl_assertions.sv
// Port-level checks of the serial port control block.
// Assumes one clock domain; bound to every uart_ctl instance.
module uart_ctl_assertions #(
	parameter int CHANNEL = 0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] hrdata,
	input wire logic transmit_ready_flag,
	input wire logic fifo_full_flag,
	input wire logic fifo_full_select,
	input wire logic tx_holding_write,
	input wire logic tx_holding_accept,
	input wire logic serial_clk_en,
	input wire logic irq_n,
	input wire logic dma_req_ch2,
	input wire logic dma_req_ch3,
	input wire logic int_ack,
	input wire logic ack_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// All checks share the bus clock and are idle in reset
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_accept;
		tx_holding_write && !transmit_ready_flag |-> !tx_holding_accept;
	endproperty
	a_accept: assert property (p_accept) else $error("write taken while not ready");
	property p_dma_cause;
		dma_req_ch2 || dma_req_ch3 |-> fifo_full_flag && fifo_full_select;
	endproperty
	a_dma_cause: assert property (p_dma_cause) else $error("dma request without full");
	property p_dma_route;
		!(CHANNEL == 0 ? dma_req_ch3 : dma_req_ch2);
	endproperty
	a_dma_route: assert property (p_dma_route) else $error("dma on wrong channel");
	property p_dma_irq;
		dma_req_ch2 || dma_req_ch3 |-> !irq_n;
	endproperty
	a_dma_irq: assert property (p_dma_irq) else $error("unmasked full without irq");
	property p_ack_follow;
		int_ack |=> ack_valid;
	endproperty
	a_ack_follow: assert property (p_ack_follow) else $error("ack not answered");
	property p_ack_cause;
		ack_valid |-> $past(int_ack);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack answer unasked");
	property p_rd_upper;
		hrdata[31:8] == 24'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
	// A tick can never recur within the 8 cycles after it
	property p_tick_gap;
		serial_clk_en |=> !serial_clk_en [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("serial ticks too close");
endmodule

bind uart_ctl uart_ctl_assertions #(.CHANNEL(CHANNEL)) uart_ctl_assertions_i (
	.clk(clk), .sys_rst(sys_rst), .hrdata(hrdata),
	.transmit_ready_flag(transmit_ready_flag),
	.fifo_full_flag(fifo_full_flag), .fifo_full_select(fifo_full_select),
	.tx_holding_write(tx_holding_write), .tx_holding_accept(tx_holding_accept),
	.serial_clk_en(serial_clk_en), .irq_n(irq_n), .dma_req_ch2(dma_req_ch2),
	.dma_req_ch3(dma_req_ch3), .int_ack(int_ack), .ack_valid(ack_valid));

// >>> sim/modem_partner.sv
// Line transceiver and remote terminal seen on the modem pins.
// Assumes the bench picks a forced level or flow-control echo.
module modem_partner #(
	parameter int DELAY = 3
) (
	input wire logic clk,
	input wire logic rts_n,
	input wire logic follow,
	input wire logic forced_n,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] hist = 8'hFF;
	// Terminal answers our request late, as a slow far end would
	always @(posedge clk) hist <= {hist[6:0], rts_n};
	assign cts_n = follow ? hist[DELAY - 1] : forced_n;
endmodule

// >>> sim/uart_ctl_test.sv
// Self-checking bench of the serial port control block.
// Assumes design, checker and modem model are compiled before it.
`include "uart_ctl_defines.svh"
module uart_ctl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, hsel, hwrite, hrdy, hresp, irq_n, rts_n, cts_n, follow, forced_n;
	logic txr, rxr, ff, fsel, brk, rbc, thw, tha, bsel, sce, d2, d3, ack, av, aval;
	logic [1:0] htrans;
	logic [7:0] haddr, avec;
	logic [15:0] div;
	logic [31:0] hwdata, hrdata, q;
	int err_total, checked, n;
	typedef struct packed {
		logic tx, rx, full, sel;
		logic [7:0] mask, stat, mrd;
		logic irqn, dma;
	} row_t;
	row_t rows[6] = '{
		'{1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 8'h01, 8'h00, 1'h1, 1'h0},
		'{1'h1, 1'h0, 1'h0, 1'h0, 8'h01, 8'h01, 8'h01, 1'h0, 1'h0},
		'{1'h0, 1'h1, 1'h0, 1'h0, 8'h02, 8'h02, 8'h02, 1'h0, 1'h0},
		'{1'h0, 1'h1, 1'h0, 1'h1, 8'h02, 8'h00, 8'h02, 1'h1, 1'h0},
		'{1'h0, 1'h0, 1'h1, 1'h1, 8'h02, 8'h02, 8'h02, 1'h0, 1'h1},
		'{1'h1, 1'h1, 1'h1, 1'h0, 8'h7B, 8'h03, 8'h03, 1'h0, 1'h0}};

	uart_ctl uart_ctl_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
		.hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .transmit_ready_flag(txr),
		.receive_ready_flag(rxr), .fifo_full_flag(ff), .fifo_full_select(fsel),
		.break_edge(brk), .reset_break_change(rbc), .tx_holding_write(thw),
		.tx_holding_accept(tha), .bus_clock_select(bsel), .baud_divider(div),
		.serial_clk_en(sce), .irq_n(irq_n), .dma_req_ch2(d2), .dma_req_ch3(d3),
		.int_ack(ack), .ack_vector(avec), .ack_autovector(av), .ack_valid(aval),
		.cts_n(cts_n), .rts_n(rts_n));
	modem_partner modem_partner_i (.clk(clk), .rts_n(rts_n), .follow(follow),
		.forced_n(forced_n), .cts_n(cts_n));

	// Bus clock, 100 ns period
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Tests take a few hundred cycles; 20000 means a hang
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single transfer; only the watchdog ends a wait on hready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hrdy !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'h1);
		q = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'h0, a, 32'h0);
		chk(nm, q, e);
	endtask

	// The pin moves only after the data phase's closing edge
	task automatic rts_step(input logic [7:0] a, input logic [31:0] d, input logic e);
		bus(1'h1, a, d);
		@(posedge clk);
		chk("rts_n", rts_n, e);
	endtask

	task automatic give_verdict();
		$display("Counts: %0d compared, %0d mismatched", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{hsel, hwrite, txr, rxr, ff, fsel, brk, rbc, thw, bsel, ack, follow} = '0;
		{htrans, haddr, hwdata} = '0;
		sys_rst = 1'h1;
		forced_n = 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		chk("rts_n reset", rts_n, 1'h1);
		rd(8'h30, 32'h0, "unmapped");
		chk("hresp", hresp, 1'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			txr <= rows[i].tx;
			rxr <= rows[i].rx;
			ff <= rows[i].full;
			fsel <= rows[i].sel;
			thw <= rows[i].rx;
			bus(1'h1, `OFS_INT_MASK, {24'h0, rows[i].mask});
			rd(`OFS_INT_STATUS, {24'h0, rows[i].stat}, "status");
			chk("irq_n", irq_n, rows[i].irqn);
			chk("dma", {d3, d2}, {1'h0, rows[i].dma});
			chk("accept", tha, rows[i].tx & rows[i].rx);
			rd(`OFS_INT_MASK, {24'h0, rows[i].mrd}, "mask");
		end
		$display("table test done");
		{txr, rxr, ff, thw} <= 4'h0;
		brk <= 1'h1;
		@(posedge clk);
		brk <= 1'h0;
		rd(`OFS_INT_STATUS, 32'h04, "break set");
		rd(`OFS_INT_STATUS, 32'h04, "break held");
		rbc <= 1'h1;
		@(posedge clk);
		rbc <= 1'h0;
		rd(`OFS_INT_STATUS, 32'h00, "break cleared");
		// A break edge in the same cycle as the reset command must win
		brk <= 1'h1;
		rbc <= 1'h1;
		@(posedge clk);
		brk <= 1'h0;
		rbc <= 1'h0;
		rd(`OFS_INT_STATUS, 32'h04, "break beats clear");
		bus(1'h1, `OFS_INT_VECTOR, 32'h5A);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		rd(`OFS_INT_STATUS, 32'h00, "status after reset");
		rd(`OFS_INT_VECTOR, 32'h0F, "vector after reset");
		$display("break test done");
		bus(1'h1, `OFS_DIV_UPPER, 32'h12);
		bus(1'h1, `OFS_DIV_LOWER, 32'h34);
		@(posedge clk);
		chk("divider", div, 16'h1234);
		rd(`OFS_DIV_UPPER, 32'h0, "upper read");
		rd(`OFS_DIV_LOWER, 32'h0, "lower read");
		bus(1'h1, `OFS_DIV_UPPER, 32'h00);
		bus(1'h1, `OFS_DIV_LOWER, 32'h02);
		bsel <= 1'h1;
		do @(posedge clk); while (sce !== 1'h1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sce !== 1'h1);
		chk("tick gap", n, 32'h40);
		$display("divider test done");
		bus(1'h1, `OFS_AUX_CTRL, 32'h01);
		forced_n <= 1'h0;
		repeat (5) @(posedge clk);
		rd(`OFS_INT_STATUS, 32'h80, "cts change");
		rd(`OFS_INPUT_PORT, 32'h00, "cts low");
		rd(`OFS_INPUT_CHANGE, 32'h10, "change reg");
		rd(`OFS_INT_STATUS, 32'h00, "change read clears");
		bus(1'h1, `OFS_AUX_CTRL, 32'h00);
		forced_n <= 1'h1;
		repeat (5) @(posedge clk);
		rd(`OFS_INT_STATUS, 32'h00, "change not enabled");
		rd(`OFS_INPUT_PORT, 32'h01, "cts high");
		$display("cts test done");
		rts_step(`OFS_OUT_ASSERT, 32'hFE, 1'h1);
		rts_step(`OFS_OUT_ASSERT, 32'h01, 1'h0);
		rts_step(`OFS_OUT_NEGATE, 32'h00, 1'h0);
		rts_step(`OFS_OUT_NEGATE, 32'h01, 1'h1);
		rts_step(`OFS_OUT_ASSERT, 32'h01, 1'h0);
		rd(`OFS_OUT_ASSERT, 32'h0, "command read");
		follow <= 1'h1;
		repeat (8) @(posedge clk);
		rd(`OFS_INPUT_PORT, 32'h00, "echoed cts");
		$display("rts test done");
		bus(1'h1, `OFS_INT_VECTOR, 32'hA5);
		rd(`OFS_INT_VECTOR, 32'hA5, "vector");
		ack <= 1'h1;
		@(posedge clk);
		ack <= 1'h0;
		@(posedge clk);
		chk("ack", {aval, av, avec}, {2'h2, 8'hA5});
		bus(1'h1, `OFS_AUX_CTRL, 32'h02);
		ack <= 1'h1;
		@(posedge clk);
		ack <= 1'h0;
		@(posedge clk);
		chk("autovector", {aval, av}, 2'h3);
		$display("vector test done");
		give_verdict();
	end
endmodule
